// File: rtl/rpos_top.sv
// Output side of the peripheral-to-pin remapping matrix for pins 32 to 39
//
// Behaviour
// - Low code field of first register selects function driving pin 32.
// - High code field of second register selects function driving pin 35.
// - Low code field of second register selects function driving pin 34.
// - High code field of third register selects function driving pin 37.
// - Low code field of third register selects function driving pin 36.
// - High code field of fourth register selects function driving pin 39.
// - Low code field of fourth register selects function driving pin 38.
// - Bits 15 and 14 ignore writes and read zero.
// - Bits 7 and 6 ignore writes and read zero.
//
// Design decisions made here: the strobed register port and the register addresses.
`default_nettype none

module rpos_top
  import rpos_pkg::*;
#(
  parameter int FUNCS = FUNC_COUNT
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Register port
  input  wire logic [ADDR_WIDTH-1:0] reg_addr,
  input  wire logic [REG_WIDTH-1:0]  reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [REG_WIDTH-1:0]  reg_rdata,
  // Peripheral output functions
  input  wire logic [FUNCS-1:0]      periph_out,
  // Remappable pin levels
  output logic                       remappable_pin_32,
  output logic                       remappable_pin_33,
  output logic                       remappable_pin_34,
  output logic                       remappable_pin_35,
  output logic                       remappable_pin_36,
  output logic                       remappable_pin_37,
  output logic                       remappable_pin_38,
  output logic                       remappable_pin_39,
  // Remappable pin output enables
  output logic                       remappable_pin_32_oe,
  output logic                       remappable_pin_33_oe,
  output logic                       remappable_pin_34_oe,
  output logic                       remappable_pin_35_oe,
  output logic                       remappable_pin_36_oe,
  output logic                       remappable_pin_37_oe,
  output logic                       remappable_pin_38_oe,
  output logic                       remappable_pin_39_oe,
  // Current function codes
  output logic      [CODE_WIDTH-1:0] pin32_function_code,
  output logic      [CODE_WIDTH-1:0] pin33_function_code,
  output logic      [CODE_WIDTH-1:0] pin34_function_code,
  output logic      [CODE_WIDTH-1:0] pin35_function_code,
  output logic      [CODE_WIDTH-1:0] pin36_function_code,
  output logic      [CODE_WIDTH-1:0] pin37_function_code,
  output logic      [CODE_WIDTH-1:0] pin38_function_code,
  output logic      [CODE_WIDTH-1:0] pin39_function_code
);

  // ****************************************
  // Register file
  // ****************************************
  rpos_pair_t                 pair       [NUM_REGS];
  logic       [REG_WIDTH-1:0] sel_rdata  [NUM_REGS];
  logic       [REG_WIDTH-1:0] sel_masked [NUM_REGS];
  logic       [REG_WIDTH-1:0] sel_acc    [NUM_REGS+1];
  logic       [NUM_REGS-1:0]  sel_hit;

  assign sel_acc[0] = READ_IDLE;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      assign sel_hit[gi] = (reg_addr == SEL_OFFSET[gi]);

      rpos_select_reg u_reg (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (reg_wr && sel_hit[gi]),
        .wdata   (reg_wdata),
        .pair    (pair[gi]),
        .rdata   (sel_rdata[gi])
      );

      assign sel_masked[gi]  = sel_hit[gi] ? sel_rdata[gi] : READ_IDLE;
      assign sel_acc[gi + 1] = sel_acc[gi] | sel_masked[gi];
    end
  endgenerate

  // ****************************************
  // Code to pin mapping
  // ****************************************
  logic [CODE_WIDTH-1:0] pin_code [NUM_PINS];

  assign pin_code[0] = pair[0].lo_code;
  assign pin_code[1] = pair[0].hi_code;
  assign pin_code[2] = pair[1].lo_code;
  assign pin_code[3] = pair[1].hi_code;
  assign pin_code[4] = pair[2].lo_code;
  assign pin_code[5] = pair[2].hi_code;
  assign pin_code[6] = pair[3].lo_code;
  assign pin_code[7] = pair[3].hi_code;

  assign pin32_function_code = pin_code[0];
  assign pin33_function_code = pin_code[1];
  assign pin34_function_code = pin_code[2];
  assign pin35_function_code = pin_code[3];
  assign pin36_function_code = pin_code[4];
  assign pin37_function_code = pin_code[5];
  assign pin38_function_code = pin_code[6];
  assign pin39_function_code = pin_code[7];

  // ****************************************
  // Pin drivers
  // ****************************************
  rpos_pin_t             pin    [NUM_PINS];
  logic [NUM_PINS-1:0]   pin_oe;

  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      rpos_pin_driver #(
        .FUNCS (FUNCS)
      ) u_drv (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .code       (pin_code[gi]),
        .periph_out (periph_out),
        .pin        (pin[gi])
      );
      assign pin_oe[gi] = pin[gi].oe;
    end
  endgenerate

  assign remappable_pin_32    = pin[0].level;
  assign remappable_pin_33    = pin[1].level;
  assign remappable_pin_34    = pin[2].level;
  assign remappable_pin_35    = pin[3].level;
  assign remappable_pin_36    = pin[4].level;
  assign remappable_pin_37    = pin[5].level;
  assign remappable_pin_38    = pin[6].level;
  assign remappable_pin_39    = pin[7].level;
  assign remappable_pin_32_oe = pin[0].oe;
  assign remappable_pin_33_oe = pin[1].oe;
  assign remappable_pin_34_oe = pin[2].oe;
  assign remappable_pin_35_oe = pin[3].oe;
  assign remappable_pin_36_oe = pin[4].oe;
  assign remappable_pin_37_oe = pin[5].oe;
  assign remappable_pin_38_oe = pin[6].oe;
  assign remappable_pin_39_oe = pin[7].oe;

  // ****************************************
  // Read port
  // ****************************************
  logic                 status_hit;
  logic [REG_WIDTH-1:0] status_word;
  logic [REG_WIDTH-1:0] read_mux;
  logic [REG_WIDTH-1:0] next_rdata;

  // Status shows which pins are currently driven
  assign status_hit  = (reg_addr == OFS_PIN_STATUS);
  assign status_word = {{(REG_WIDTH-NUM_PINS){1'b0}}, pin_oe};
  assign read_mux    = sel_acc[NUM_REGS] | (status_hit ? status_word : READ_IDLE);
  // Data only in the cycle after the read strobe; unmapped reads zero
  assign next_rdata  = reg_rd ? read_mux : READ_IDLE;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= READ_IDLE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// File: rtl/rpos_pkg.sv
// Constants and types for the remappable pin output select block
`default_nettype none

package rpos_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int REG_WIDTH  = 16;
  localparam int CODE_WIDTH = 6;
  localparam int ADDR_WIDTH = 4;
  localparam int NUM_REGS   = 4;
  localparam int NUM_PINS   = 8;
  localparam int FUNC_COUNT = 64;
  localparam int FIRST_PIN  = 32;

  // ****************************************
  // Field layout of one output-select register
  // ****************************************
  localparam int LO_CODE_LSB = 0;
  localparam int HI_CODE_LSB = 8;
  localparam int LO_GAP_BITS = HI_CODE_LSB - LO_CODE_LSB - CODE_WIDTH;
  localparam int HI_GAP_BITS = REG_WIDTH - HI_CODE_LSB - CODE_WIDTH;

  // ****************************************
  // Reset values and special codes
  // ****************************************
  localparam logic [CODE_WIDTH-1:0] CODE_RESET      = 6'h00;
  localparam logic [CODE_WIDTH-1:0] CODE_UNASSIGNED = 6'h00;
  localparam logic [REG_WIDTH-1:0]  READ_IDLE       = 16'h0000;

  // ****************************************
  // Register offsets (word index on the register port)
  // ****************************************
  localparam logic [ADDR_WIDTH-1:0] OFS_SEL_PINS_32_33 = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] OFS_SEL_PINS_34_35 = 4'h1;
  localparam logic [ADDR_WIDTH-1:0] OFS_SEL_PINS_36_37 = 4'h2;
  localparam logic [ADDR_WIDTH-1:0] OFS_SEL_PINS_38_39 = 4'h3;
  localparam logic [ADDR_WIDTH-1:0] OFS_PIN_STATUS     = 4'h4;
  localparam logic [ADDR_WIDTH-1:0] SEL_OFFSET [NUM_REGS] = '{
    OFS_SEL_PINS_32_33, OFS_SEL_PINS_34_35, OFS_SEL_PINS_36_37, OFS_SEL_PINS_38_39
  };

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [CODE_WIDTH-1:0] hi_code;
    logic [CODE_WIDTH-1:0] lo_code;
  } rpos_pair_t;

  typedef struct packed {
    logic level;
    logic oe;
  } rpos_pin_t;

endpackage

`default_nettype wire

// File: rtl/rpos_select_reg.sv
// One output-select register holding two pin function codes
`default_nettype none

module rpos_select_reg
  import rpos_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Write side
  input  wire logic                 wr_en,
  input  wire logic [REG_WIDTH-1:0] wdata,
  // Stored state
  output var rpos_pair_t            pair,
  output logic      [REG_WIDTH-1:0] rdata
);

  rpos_pair_t next_pair;

  // Only the two code fields are taken; gap bits are dropped
  assign next_pair.hi_code = wr_en ? wdata[HI_CODE_LSB +: CODE_WIDTH] : pair.hi_code;
  assign next_pair.lo_code = wr_en ? wdata[LO_CODE_LSB +: CODE_WIDTH] : pair.lo_code;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pair.hi_code <= CODE_RESET;
      pair.lo_code <= CODE_RESET;
    end else begin
      pair <= next_pair;
    end
  end

  // Unimplemented bits read as zero
  assign rdata = {{HI_GAP_BITS{1'b0}}, pair.hi_code,
                  {LO_GAP_BITS{1'b0}}, pair.lo_code};

endmodule

`default_nettype wire

// File: rtl/rpos_pin_driver.sv
// Drives one remappable pin from the peripheral output chosen by its code
`default_nettype none

module rpos_pin_driver
  import rpos_pkg::*;
#(
  parameter int FUNCS = FUNC_COUNT
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Selection
  input  wire logic [CODE_WIDTH-1:0] code,
  input  wire logic [FUNCS-1:0]      periph_out,
  // Pin
  output var rpos_pin_t              pin
);

  logic      code_in_range;
  logic      assigned;
  logic      chosen;
  rpos_pin_t next_pin;

  assign code_in_range = 32'(code) < FUNCS;
  assign assigned      = (code != CODE_UNASSIGNED) && code_in_range;
  assign chosen        = code_in_range ? periph_out[code] : 1'b0;
  assign next_pin.oe    = assigned;
  assign next_pin.level = assigned ? chosen : 1'b0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin <= '0;
    end else begin
      pin <= next_pin;
    end
  end

endmodule

`default_nettype wire

// File: testbench/rpos_chk_sva.sv
// Port assertions for the remappable pin output select block
`default_nettype none

module rpos_chk
  import rpos_pkg::*;
#(
  parameter int FUNCS = FUNC_COUNT
) (
  // Clock, reset and register port
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic [REG_WIDTH-1:0]  reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [REG_WIDTH-1:0]  reg_rdata,
  // Functions and pins
  input wire logic [FUNCS-1:0]      periph_out,
  input wire logic                  remappable_pin_32,
  input wire logic                  remappable_pin_32_oe,
  input wire logic [CODE_WIDTH-1:0] pin32_function_code,
  input wire logic [CODE_WIDTH-1:0] pin33_function_code,
  input wire logic [CODE_WIDTH-1:0] pin34_function_code,
  input wire logic [CODE_WIDTH-1:0] pin35_function_code,
  input wire logic [CODE_WIDTH-1:0] pin36_function_code,
  input wire logic [CODE_WIDTH-1:0] pin37_function_code,
  input wire logic [CODE_WIDTH-1:0] pin38_function_code,
  input wire logic [CODE_WIDTH-1:0] pin39_function_code
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Decode and assertions
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic       wr0   = reg_wr && reg_addr == OFS_SEL_PINS_32_33;
  wire logic       wr1   = reg_wr && reg_addr == OFS_SEL_PINS_34_35;
  wire logic       wr2   = reg_wr && reg_addr == OFS_SEL_PINS_36_37;
  wire logic       wr3   = reg_wr && reg_addr == OFS_SEL_PINS_38_39;
  wire logic       rdsel = reg_rd && reg_addr < 4'h4;
  wire logic [5:0] wlo   = reg_wdata[5:0];
  wire logic [5:0] whi   = reg_wdata[13:8];
  wire logic       sel32 = periph_out[pin32_function_code];

  chk_lo_code_32: assert property (wr0 |=> pin32_function_code == $past(wlo))
    else $error("pin 32 code not taken from write");
  chk_hi_code_33: assert property (wr0 |=> pin33_function_code == $past(whi))
    else $error("pin 33 code not taken from write");
  chk_lo_code_34: assert property (wr1 |=> pin34_function_code == $past(wlo))
    else $error("pin 34 code not taken from write");
  chk_hi_code_35: assert property (wr1 |=> pin35_function_code == $past(whi))
    else $error("pin 35 code not taken from write");
  chk_lo_code_36: assert property (wr2 |=> pin36_function_code == $past(wlo))
    else $error("pin 36 code not taken from write");
  chk_hi_code_37: assert property (wr2 |=> pin37_function_code == $past(whi))
    else $error("pin 37 code not taken from write");
  chk_lo_code_38: assert property (wr3 |=> pin38_function_code == $past(wlo))
    else $error("pin 38 code not taken from write");
  chk_hi_code_39: assert property (wr3 |=> pin39_function_code == $past(whi))
    else $error("pin 39 code not taken from write");
  chk_top_gap_zero: assert property (rdsel |=> reg_rdata[15:14] == 2'b00)
    else $error("read bits 15 to 14 not zero");
  chk_mid_gap_zero: assert property (rdsel |=> reg_rdata[7:6] == 2'b00)
    else $error("read bits 7 to 6 not zero");
  chk_code_holds: assert property (!wr3 |=> $stable(pin39_function_code))
    else $error("pin 39 code changed without a write");
  chk_pin_follows: assert property (pin32_function_code != 6'h00 |=>
    remappable_pin_32_oe && remappable_pin_32 == $past(sel32))
    else $error("pin 32 does not follow its function");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
endmodule

`default_nettype wire

// File: testbench/rpos_periph_model.sv
// Peripheral output functions seen by the remapping matrix
`default_nettype none

module rpos_periph_model
  import rpos_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [FUNC_COUNT-1:0] pattern,
  output logic      [FUNC_COUNT-1:0] periph_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Peripherals update their outputs on the system clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) periph_out <= '0;
    else periph_out <= pattern;
  end
endmodule

`default_nettype wire

// File: testbench/tb_rpos_top.sv
// Self-checking bench for the remappable pin output select block
`default_nettype none

module tb_rpos_top
  import rpos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [63:0] pattern = 64'h0;
  wire  [15:0] reg_rdata;
  wire  [63:0] periph_out;
  wire  [7:0]  pin, oe;
  wire  [5:0]  code [8];
  int          err_total = 0, num_checks = 0;

  rpos_periph_model part_u (.sys_clk(sys_clk), .rst(rst), .pattern(pattern),
    .periph_out(periph_out));
  rpos_top dut_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_out(periph_out),
    .remappable_pin_32(pin[0]), .remappable_pin_33(pin[1]), .remappable_pin_34(pin[2]),
    .remappable_pin_35(pin[3]), .remappable_pin_36(pin[4]), .remappable_pin_37(pin[5]),
    .remappable_pin_38(pin[6]), .remappable_pin_39(pin[7]),
    .remappable_pin_32_oe(oe[0]), .remappable_pin_33_oe(oe[1]), .remappable_pin_34_oe(oe[2]),
    .remappable_pin_35_oe(oe[3]), .remappable_pin_36_oe(oe[4]), .remappable_pin_37_oe(oe[5]),
    .remappable_pin_38_oe(oe[6]), .remappable_pin_39_oe(oe[7]),
    .pin32_function_code(code[0]), .pin33_function_code(code[1]),
    .pin34_function_code(code[2]), .pin35_function_code(code[3]),
    .pin36_function_code(code[4]), .pin37_function_code(code[5]),
    .pin38_function_code(code[6]), .pin39_function_code(code[7]));

  // ****************************************
  // Tasks
  // ****************************************
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (int r = 0; r < 4; r++) rd(4'(r), 16'h0000);
    for (int r = 0; r < 4; r++) begin
      wr(4'(r), 16'hffff);
      rd(4'(r), 16'h3f3f);
      wr(4'(r), {2'b11, 6'(2 * r + 2), 2'b11, 6'(2 * r + 1)});
      rd(4'(r), {8'(2 * r + 2), 8'(2 * r + 1)});
    end
    $display("register test done");
    for (int k = 0; k < 2; k++) begin
      pattern <= k ? 64'h5555555555555555 : 64'haaaaaaaaaaaaaaaa;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      for (int p = 0; p < 8; p++) begin
        chk(16'(code[p]), 16'(p + 1));
        chk(16'({oe[p], pin[p]}), 16'({1'b1, pattern[p + 1]}));
      end
    end
    $display("pin test done");
    wr(4'h5, 16'h0707);
    rd(4'h5, 16'h0000);
    rd(4'h4, 16'h00ff);
    rd(4'h0, 16'h0201);
    $display("unmapped test done");
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h3, 16'h0000);
    chk(16'(code[7]), 16'h0000);
    chk(16'(oe), 16'h0000);
    $display("reset test done");
    finish_test();
  end

  initial begin
    repeat (2000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end
endmodule

bind rpos_top rpos_chk #(.FUNCS(FUNCS)) chk_u (.*);

`default_nettype wire
